// *** rtl/smbus_blk_host.sv ***
// host end: issues indexed block writes on the two-wire bus
`default_nettype none
module smbus_blk_host
   import smbus_blk_pkg::*;
#(
   parameter int HALF = HALF_PERIOD
) (
   input  wire logic         ref_clk,
   input  wire logic         srst,
   smbus_blk_if.host         bus,
   input  wire logic         go,
   input  wire logic [6:0]   tgt_addr,
   input  wire logic [7:0]   start_index,
   input  wire logic [7:0]   byte_count,
   input  wire logic         data_valid,
   input  wire logic [7:0]   data_in,
   output logic              data_taken,
   output logic              busy,
   output logic              done,
   output logic              nack
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b010,
      H_ACK = 3'b011, H_STOP = 3'b100, H_LOAD = 3'b101
   } hstate_e;
   hstate_e    st_q;
   logic [15:0] tick_q;
   logic [1:0] ph_q;
   logic [7:0] sh_q, cnt_q, idx_q;
   logic [1:0] stage_q;
   logic [3:0] bit_q;
   logic       err_q;
   wire        tick = (tick_q == 16'(HALF - 1));
   always_ff @(posedge ref_clk) begin
      data_taken <= 1'b0;
      done <= 1'b0;
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
      if (srst) begin
         st_q <= H_IDLE;
         tick_q <= 16'h0000;
         ph_q <= 2'b00;
         sh_q <= 8'h00;
         cnt_q <= 8'h00;
         idx_q <= 8'h00;
         stage_q <= 2'b00;
         bit_q <= 4'h0;
         err_q <= 1'b0;
         busy <= 1'b0;
         nack <= 1'b0;
         bus.scl_o <= 1'b1;
         bus.scl_oe <= 1'b0;
         bus.sda_host_o <= 1'b1;
         bus.sda_host_oe <= 1'b0;
      end else begin
         case (st_q)
            H_IDLE: if (go) begin
               st_q <= H_START;
               busy <= 1'b1;
               nack <= 1'b0;
               err_q <= 1'b0;
               cnt_q <= byte_count;
               idx_q <= start_index;
               sh_q <= {tgt_addr, DIR_WRITE};
               stage_q <= 2'b00;
               ph_q <= 2'b00;
            end
            H_START: if (tick) begin
               bus.sda_host_o <= 1'b0;
               bus.sda_host_oe <= 1'b1;
               st_q <= H_BIT;
               bit_q <= 4'h0;
            end
            H_BIT, H_ACK: if (tick) begin
               ph_q <= ph_q + 2'b01;
               case (ph_q)
                  2'b00: begin
                     bus.scl_o <= 1'b0;
                     bus.scl_oe <= 1'b1;
                  end
                  2'b01: begin
                     bus.sda_host_o <= (st_q == H_BIT) ? sh_q[7] : 1'b1;
                     bus.sda_host_oe <= (st_q == H_BIT) ? ~sh_q[7] : 1'b0;
                  end
                  2'b10: bus.scl_oe <= 1'b0;
                  default: begin
                     ph_q <= 2'b00;
                     if (st_q == H_BIT) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == BITS_PER_BYTE - 4'h1) begin
                           st_q <= H_ACK;
                        end
                     end else if (bus.sda) begin
                        err_q <= 1'b1;
                        st_q <= H_STOP;
                     end else begin
                        st_q <= H_LOAD;
                     end
                  end
               endcase
            end
            H_LOAD: begin
               bit_q <= 4'h0;
               if (stage_q == 2'b00) begin
                  sh_q <= idx_q;
                  stage_q <= 2'b01;
                  st_q <= H_BIT;
               end else if (stage_q == 2'b01) begin
                  sh_q <= cnt_q;
                  stage_q <= 2'b10;
                  st_q <= H_BIT;
               end else if (cnt_q == 8'h00) begin
                  st_q <= H_STOP;
               end else if (data_valid) begin
                  sh_q <= data_in;
                  data_taken <= 1'b1;
                  cnt_q <= cnt_q - 8'h01;
                  st_q <= H_BIT;
               end
            end
            default: if (tick) begin
               ph_q <= ph_q + 2'b01;
               case (ph_q)
                  2'b00: begin
                     bus.scl_o <= 1'b0;
                     bus.scl_oe <= 1'b1;
                  end
                  2'b01: begin
                     bus.sda_host_o <= 1'b0;
                     bus.sda_host_oe <= 1'b1;
                  end
                  2'b10: bus.scl_oe <= 1'b0;
                  default: begin
                     bus.sda_host_oe <= 1'b0;
                     ph_q <= 2'b00;
                     st_q <= H_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                     nack <= err_q;
                  end
               endcase
            end
         endcase
      end
   end
endmodule : smbus_blk_host
`default_nettype wire

// *** rtl/smbus_blk_pkg.sv ***
// constants shared by both ends of the block-write serial link
`default_nettype none
package smbus_blk_pkg;
   localparam logic [6:0] ADDR_STRAP_0  = 7'h68;
   localparam logic [6:0] ADDR_STRAP_1  = 7'h6A;
   localparam logic       DIR_WRITE     = 1'b0;
   localparam int         HALF_PERIOD   = 50;
   localparam int         BIT_W         = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : smbus_blk_pkg
`default_nettype wire

// *** rtl/smbus_blk_if.sv ***
// two-wire bus carrier joining host and target
`default_nettype none
interface smbus_blk_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_tgt_o;
   logic sda_tgt_oe;
   logic scl;
   logic sda;
   assign scl = (scl_oe & ~scl_o) ? 1'b0 : 1'b1;
   assign sda = ((sda_host_oe & ~sda_host_o) | (sda_tgt_oe & ~sda_tgt_o))
                ? 1'b0 : 1'b1;
   modport host (output scl_o, scl_oe, sda_host_o, sda_host_oe,
                 input scl, sda);
   modport target (output sda_tgt_o, sda_tgt_oe, input scl, sda);
endinterface : smbus_blk_if
`default_nettype wire

// *** rtl/smbus_blk_target.sv ***
// target end: receives indexed block writes into a register file
`default_nettype none
module smbus_blk_target
   import smbus_blk_pkg::*;
#(
   parameter int DEPTH = 256
) (
   input  wire logic         ref_clk,
   input  wire logic         srst,
   smbus_blk_if.target       bus,
   input  wire logic         address_strap_select,
   input  wire logic         strap_latch,
   input  wire logic [7:0]   rd_index,
   output logic      [7:0]   rd_data,
   output logic              wr_stb,
   output logic      [7:0]   wr_index,
   output logic      [7:0]   wr_data,
   output logic              busy
);
   typedef enum logic [2:0] {
      T_IDLE = 3'b000, T_ADDR = 3'b001, T_INDEX = 3'b010,
      T_COUNT = 3'b011, T_DATA = 3'b100, T_IGNORE = 3'b101
   } tstate_e;
   tstate_e    st_q;
   logic       scl_q, sda_q, strap_q, strap_done_q, ack_q;
   logic [7:0] sh_q, idx_q, cnt_q;
   logic [3:0] bit_q;
   logic [7:0] mem_q [DEPTH];
   wire        scl_rise  = bus.scl & ~scl_q;
   wire        scl_fall  = ~bus.scl & scl_q;
   wire        start_det = bus.scl & scl_q & sda_q & ~bus.sda;
   wire        stop_det  = bus.scl & scl_q & ~sda_q & bus.sda;
   wire [6:0]  my_addr   = strap_q ? ADDR_STRAP_1 : ADDR_STRAP_0;
   wire [7:0]  byte_in   = {sh_q[6:0], bus.sda};
   wire        last_bit  = (bit_q == BITS_PER_BYTE - 4'h1);
   wire        addr_hit  = (byte_in[7:1] == my_addr) &&
                           (byte_in[0] == DIR_WRITE);
   always_ff @(posedge ref_clk) begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      if (srst) begin
         strap_done_q <= 1'b0;
         strap_q      <= 1'b0;
      end else if (strap_latch && !strap_done_q) begin
         strap_q      <= address_strap_select;
         strap_done_q <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      wr_stb <= 1'b0;
      if (srst) begin
         st_q <= T_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         idx_q <= 8'h00;
         cnt_q <= 8'h00;
         ack_q <= 1'b0;
         wr_index <= 8'h00;
         wr_data <= 8'h00;
         bus.sda_tgt_o <= 1'b1;
         bus.sda_tgt_oe <= 1'b0;
      end else if (start_det) begin
         st_q <= T_ADDR;
         bit_q <= 4'h0;
         ack_q <= 1'b0;
         bus.sda_tgt_oe <= 1'b0;
      end else if (stop_det) begin
         st_q <= T_IDLE;
         bus.sda_tgt_oe <= 1'b0;
      end else if (scl_fall) begin
         if (ack_q) begin
            bus.sda_tgt_o <= 1'b0;
            bus.sda_tgt_oe <= 1'b1;
            ack_q <= 1'b0;
         end else begin
            bus.sda_tgt_oe <= 1'b0;
         end
      end else if (scl_rise && st_q != T_IDLE && st_q != T_IGNORE) begin
         if (bus.sda_tgt_oe) begin
            bit_q <= 4'h0;
         end else begin
            sh_q <= byte_in;
            bit_q <= bit_q + 4'h1;
            if (last_bit) begin
               case (st_q)
                  T_ADDR: begin
                     st_q  <= addr_hit ? T_INDEX : T_IGNORE;
                     ack_q <= addr_hit;
                  end
                  T_INDEX: begin
                     idx_q <= byte_in;
                     st_q  <= T_COUNT;
                     ack_q <= 1'b1;
                  end
                  T_COUNT: begin
                     cnt_q <= byte_in;
                     st_q  <= (byte_in == 8'h00) ? T_IGNORE : T_DATA;
                     ack_q <= 1'b1;
                  end
                  T_DATA: begin
                     ack_q    <= 1'b1;
                     wr_stb   <= 1'b1;
                     wr_index <= idx_q;
                     wr_data  <= byte_in;
                     idx_q    <= idx_q + 8'h01;
                     cnt_q    <= cnt_q - 8'h01;
                     if (cnt_q == 8'h01) begin
                        st_q <= T_IGNORE;
                     end
                  end
                  default: st_q <= T_IGNORE;
               endcase
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (wr_stb) begin
         mem_q[wr_index] <= wr_data;
      end
      rd_data <= mem_q[rd_index];
      busy <= srst ? 1'b0 : (st_q != T_IDLE);
   end
endmodule : smbus_blk_target
`default_nettype wire

// *** test/smbus_blk_props.sv ***
// wire-level checker for the block-write link
`default_nettype none
module smbus_blk_props (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_oe,
   input wire logic sda_host_oe,
   input wire logic sda_tgt_o,
   input wire logic sda_tgt_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [3:0] cnt_q;
   logic       scl_q;
   logic       sda_q;
   wire        tgt_low = sda_tgt_oe & ~sda_tgt_o;
   wire        edge_w = scl & scl_q & (sda_q ^ sda);
   wire        rise_w = scl & ~scl_q;
   wire [3:0]  cnt_d = (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
   // bit position within the current nine-bit slot
   always_ff @(posedge ref_clk) begin
      scl_q <= srst | scl;
      sda_q <= srst | sda;
      if (srst | edge_w) cnt_q <= 4'h0;
      else if (rise_w) cnt_q <= cnt_d;
   end
   sequence s_start; scl && $past(scl) && $fell(sda); endsequence
   sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
   property p_start; s_start |-> cnt_q == 4'h0; endproperty
   property p_stop; s_stop |-> cnt_q == 4'h1; endproperty
   property p_idle; $fell(srst) |-> !scl_oe && !sda_host_oe && !sda_tgt_oe;
   endproperty
   property p_ack_win;
      tgt_low |-> cnt_q == 4'h9 || (cnt_q == 4'h8 && !(scl && scl_q));
   endproperty
   property p_ack_hold; scl && scl_q && $past(tgt_low) |-> tgt_low;
   endproperty
   property p_ack_steady; scl && scl_q && cnt_q == 4'h9 |-> $stable(sda);
   endproperty
   property p_data_steady;
      scl && scl_q && cnt_q >= 4'h2 && cnt_q <= 4'h8 |-> $stable(sda);
   endproperty
   property p_ack_low; $rose(tgt_low) |-> !scl; endproperty
   a_start:
      assert property (p_start) else $error("start inside a transfer");
   a_stop:
      assert property (p_stop) else $error("stop not after an ack slot");
   a_idle:
      assert property (p_idle) else $error("bus driven after reset");
   a_ack_win:
      assert property (p_ack_win) else $error("target low outside ack");
   a_ack_hold:
      assert property (p_ack_hold) else $error("ack dropped while scl high");
   a_ack_steady:
      assert property (p_ack_steady) else $error("ack bit moved");
   a_data_steady:
      assert property (p_data_steady) else $error("data moved, scl high");
   a_ack_low:
      assert property (p_ack_low) else $error("ack raised with scl high");
endmodule : smbus_blk_props
`default_nettype wire

// *** test/smbus_block_write_target_test.sv ***
// self-checking bench: host and target joined on one bus
`default_nettype none
module smbus_block_write_target_test
   import smbus_blk_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       ref_clk = 1'b0, srst = 1'b1, go = 1'b0, data_valid = 1'b1;
   logic       address_strap_select = 1'b1, strap_latch = 1'b0;
   logic [6:0] tgt_addr = 7'h00;
   logic [7:0] start_index = 8'h00, byte_count = 8'h00, data_in = 8'h00;
   logic [7:0] rd_index = 8'h00, exp_idx, exp_dat, stores, acks;
   logic [7:0] rd_data, wr_index, wr_data;
   logic       data_taken, done, nack, wr_stb, host_busy, tgt_busy;
   logic       oe_q = 1'b0;
   int         failures = 0, checked = 0;
   smbus_blk_if bus ();
   always #12.5 ref_clk = ~ref_clk;
   smbus_blk_host #(.HALF(4)) smbus_blk_host_i (.ref_clk(ref_clk),
      .srst(srst), .bus(bus.host), .go(go), .tgt_addr(tgt_addr),
      .start_index(start_index), .byte_count(byte_count),
      .data_valid(data_valid), .data_in(data_in), .data_taken(data_taken),
      .busy(host_busy), .done(done), .nack(nack));
   smbus_blk_target smbus_blk_target_i (.ref_clk(ref_clk), .srst(srst),
      .bus(bus.target), .address_strap_select(address_strap_select),
      .strap_latch(strap_latch), .rd_index(rd_index), .rd_data(rd_data),
      .wr_stb(wr_stb), .wr_index(wr_index), .wr_data(wr_data),
      .busy(tgt_busy));
   smbus_blk_props smbus_blk_props_i (.ref_clk(ref_clk), .srst(srst),
      .scl(bus.scl), .sda(bus.sda), .scl_oe(bus.scl_oe),
      .sda_host_oe(bus.sda_host_oe), .sda_tgt_o(bus.sda_tgt_o),
      .sda_tgt_oe(bus.sda_tgt_oe));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // every store lands at the next index with the next byte
   always @(posedge ref_clk) begin
      oe_q <= bus.sda_tgt_oe;
      if (bus.sda_tgt_oe === 1'b1 && oe_q !== 1'b1) acks++;
      if (wr_stb === 1'b1) begin
         check(wr_index, exp_idx);
         check(wr_data, exp_dat);
         exp_idx++;
         exp_dat++;
         stores++;
      end
   end
   task automatic blk_write(input logic [6:0] a, input logic [7:0] n,
      input logic [7:0] x, input logic nk, input logic [7:0] ns);
      int t;
      exp_idx = n;
      exp_dat = n ^ 8'h5a;
      stores = 8'h00;
      acks = 8'h00;
      t = 0;
      @(posedge ref_clk);
      go <= 1'b1;
      tgt_addr <= a;
      start_index <= n;
      byte_count <= x;
      data_in <= n ^ 8'h5a;
      @(posedge ref_clk);
      go <= 1'b0;
      while (done !== 1'b1 && t < 20000) begin
         @(posedge ref_clk);
         data_valid <= (t % 4) != 0;
         if (data_taken === 1'b1) begin
            data_in <= data_in + 8'h01;
            check({7'h00, host_busy}, 8'h01);
            check({7'h00, tgt_busy}, 8'h01);
         end
         t++;
      end
      if (t >= 20000) failures++;
      repeat (3) @(posedge ref_clk);
      check({7'h00, host_busy}, 8'h00);
      check({7'h00, tgt_busy}, 8'h00);
      check(acks, nk ? 8'h00 : 8'h03 + x);
      check({7'h00, nack}, {7'h00, nk});
      check(stores, ns);
      $display("test write done at %0t", $time);
   endtask : blk_write
   task automatic rd_check(input logic [7:0] i, input logic [7:0] e);
      @(posedge ref_clk);
      rd_index <= i;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check(rd_data, e);
   endtask : rd_check
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      #1_000_000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      strap_latch <= 1'b1;
      @(posedge ref_clk);
      address_strap_select <= 1'b0;
      blk_write(ADDR_STRAP_1, 8'h10, 8'h03, 1'b0, 8'h03);
      blk_write(ADDR_STRAP_0, 8'h20, 8'h02, 1'b1, 8'h00);
      blk_write(ADDR_STRAP_1, 8'hfe, 8'h04, 1'b0, 8'h04);
      blk_write(ADDR_STRAP_1, 8'h30, 8'h00, 1'b0, 8'h00);
      rd_check(8'h12, 8'h4c);
      rd_check(8'hfe, 8'ha4);
      rd_check(8'h01, 8'ha7);
      $display("test readback done at %0t", $time);
      complete_run();
   end
endmodule : smbus_block_write_target_test
`default_nettype wire
